/* verilog/gcn_global_clock_network.sv */
/*
 * Global clock network: per-line source selection, root gating, fan-out
 * to the four sink classes, control network and interface block paths.
 * Assumes source clocks are sampled on core_clk as levels; core-made
 * clocks and enables come from logic on core_clk.
 */
module gcn_global_clock_network #(
	parameter int LINES     = gcn_pkg::LINES,
	parameter int PINS_SIDE = gcn_pkg::PINS_SIDE,
	parameter int CTL_PINS  = gcn_pkg::CTL_PINS,
	parameter int IFC_N     = gcn_pkg::IFC_N
) (
	// clock and reset
	input  wire logic                       core_clk,
	input  wire logic                       rst,
	// clock sources
	input  wire logic [PINS_SIDE-1:0]       left_pin,
	input  wire logic [PINS_SIDE-1:0]       right_pin,
	input  wire logic [gcn_pkg::SYNTH_OUTS-1:0] synth_output_clock,
	input  wire logic                       osc_clk,
	input  wire logic [LINES-1:0]           core_gen_clk,
	// configuration
	input  wire logic                       run,
	input  wire logic                       cfg_valid,
	input  wire gcn_pkg::gcn_cfg_s          cfg,
	output logic                            cfg_accept_r,
	output logic                            cfg_reject_r,
	// run-time enables
	input  wire logic [LINES-1:0]           line_en,
	// distributed trees
	output gcn_pkg::gcn_tree_s              tree_r,
	// control network
	input  wire logic [CTL_PINS-1:0]        ctl_pin,
	output logic [CTL_PINS-1:0]             le_set_r,
	output logic [CTL_PINS-1:0]             le_reset_r,
	output logic [CTL_PINS-1:0]             le_ce_r,
	// alternate inputs to synth references
	input  wire logic [gcn_pkg::SYNTHS-1:0] alt_pin,
	output logic [gcn_pkg::SYNTHS-1:0]      synth_ref_r,
	// interface blocks
	input  wire gcn_pkg::gcn_ifc_s [IFC_N-1:0] ifc_in,
	output gcn_pkg::gcn_ifc_s [IFC_N-1:0]      ifc_out_r
);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	localparam int SYNC_W = 2 * PINS_SIDE + gcn_pkg::SYNTH_OUTS + 1 + CTL_PINS
		+ gcn_pkg::SYNTHS + IFC_N;

	logic [SYNC_W-1:0] meta_r;
	logic [SYNC_W-1:0] sync_r;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= {left_pin, right_pin, synth_output_clock, osc_clk, ctl_pin,
				alt_pin, ifc_in_pad(ifc_in)};
			sync_r <= meta_r;
		end
	end

	function automatic logic [IFC_N-1:0] ifc_in_pad(input gcn_pkg::gcn_ifc_s [IFC_N-1:0] v);
		logic [IFC_N-1:0] r;
		r = '0;
		for (int i = 0; i < IFC_N; i++) begin
			r[i] = v[i].to_core;
		end
		return r;
	endfunction

	logic [PINS_SIDE-1:0]           s_left;
	logic [PINS_SIDE-1:0]           s_right;
	logic [gcn_pkg::SYNTH_OUTS-1:0] s_synth;
	logic                           s_osc;
	logic [CTL_PINS-1:0]            s_ctl;
	logic [gcn_pkg::SYNTHS-1:0]     s_alt;
	logic [IFC_N-1:0]               s_ifc;

	assign {s_left, s_right, s_synth, s_osc, s_ctl, s_alt, s_ifc} = sync_r;

	// ------------------------------------------------------------
	// legality of a source for a line
	// ------------------------------------------------------------
	function automatic logic legal(input gcn_pkg::gcn_cfg_s c);
		logic [15:0] mask;
		mask = 16'h0000;
		unique case (c.kind)
			gcn_pkg::SRC_PIN: begin
				if (c.idx < 4'(PINS_SIDE)) begin
					mask = gcn_pkg::PIN_BASE_MASK << c.idx[1:0];
					if (c.line[3]) begin
						mask = mask << gcn_pkg::RIGHT_SHIFT;
					end
				end
			end
			gcn_pkg::SRC_SYNTH: begin
				if (c.idx < 4'(gcn_pkg::SYNTH_OUTS)) begin
					mask = gcn_pkg::SYNTH_MASK[c.idx];
				end
			end
			gcn_pkg::SRC_OSC: begin
				mask = 16'hffff;
			end
			gcn_pkg::SRC_CORE: begin
				mask = 16'hffff;
			end
		endcase
		return mask[c.line];
	endfunction

	// ------------------------------------------------------------
	// selection table
	// ------------------------------------------------------------
	gcn_pkg::gcn_sel_s sel_r [LINES];

	// only accepted while stopped; an illegal or late request changes nothing
	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < LINES; i++) begin
				sel_r[i] <= '{kind: gcn_pkg::SRC_CORE, idx: gcn_pkg::IDX_RST, valid: 1'b0};
			end
		end else if (cfg_valid && !run && legal(cfg)) begin
			sel_r[cfg.line] <= '{kind: cfg.kind, idx: cfg.idx, valid: 1'b1};
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			cfg_accept_r <= 1'b0;
			cfg_reject_r <= 1'b0;
		end else begin
			cfg_accept_r <= cfg_valid && !run && legal(cfg);
			cfg_reject_r <= cfg_valid && (run || !legal(cfg));
		end
	end

	// ------------------------------------------------------------
	// per-line source mux and root gate
	// ------------------------------------------------------------
	logic [LINES-1:0] gated;

	genvar g;
	generate
		for (g = 0; g < LINES; g++) begin : g_line
			logic src;

			always_comb begin
				src = 1'b0;
				unique case (sel_r[g].kind)
					gcn_pkg::SRC_PIN:   src = (g < 8) ? s_left[sel_r[g].idx[2:0]]
						: s_right[sel_r[g].idx[2:0]];
					gcn_pkg::SRC_SYNTH: src = s_synth[sel_r[g].idx];
					gcn_pkg::SRC_OSC:   src = s_osc;
					gcn_pkg::SRC_CORE:  src = core_gen_clk[sel_r[g].idx];
				endcase
				src = src & sel_r[g].valid;
			end

			gcn_root_gate u_gate (
				.core_clk (core_clk),
				.rst      (rst),
				.src      (src),
				.en       (line_en[g]),
				.gated_r  (gated[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// tree fan-out
	// ------------------------------------------------------------
	// one stage of balance: every sink class sees the same delay
	always_ff @(posedge core_clk) begin
		if (rst) begin
			tree_r <= '{le: gcn_pkg::LINE_RST, mem: gcn_pkg::LINE_RST,
				mult: gcn_pkg::LINE_RST, io: gcn_pkg::LINE_RST};
		end else begin
			tree_r <= '{le: gated, mem: gated, mult: gated, io: gated};
		end
	end

	// ------------------------------------------------------------
	// control network
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			le_set_r   <= '0;
			le_reset_r <= '0;
			le_ce_r    <= '0;
		end else begin
			le_set_r   <= s_ctl;
			le_reset_r <= s_ctl;
			le_ce_r    <= s_ctl;
		end
	end

	// ------------------------------------------------------------
	// alternate path and interface blocks
	// ------------------------------------------------------------
	// the alternate path never touches the core-side interface signals
	always_ff @(posedge core_clk) begin
		if (rst) begin
			synth_ref_r <= '0;
		end else begin
			synth_ref_r <= s_alt;
		end
	end

	// interface i takes its clock output from tree line i
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ifc_out_r <= '0;
		end else begin
			for (int i = 0; i < IFC_N; i++) begin
				ifc_out_r[i].to_core <= s_ifc[i];
				ifc_out_r[i].to_pad  <= ifc_in[i].to_pad;
				ifc_out_r[i].clk_out <= gated[i];
			end
		end
	end

endmodule

/* shared/gcn_pkg.sv */
/*
 * Constants, masks and carrier types for the global clock network.
 * Assumes every user of it writes gcn_pkg::name and never imports it.
 */
// How it works
// - sixteen global lines, each with its own tree
// - sources: pin, synth output, oscillator, core clock
// - per-line enable gate at tree root
// - gate switches at run time without runts
// - trees feed logic, memory, multipliers, interfaces
// - control pins drive set/reset/enable network
// - left pin n reaches lines n%4, n%4+4
// - right pin n reaches lines 8+n%4, 12+n%4
// - left synth outputs reach their fixed lines only
// - right synth outputs reach their fixed lines only
// - alternate pin feeds synth reference directly
// - interface clock outputs come from the tree
// - interface blocks: input, output, clock output
package gcn_pkg;

	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int LINES      = 16;
	localparam int PINS_SIDE  = 8;
	localparam int SYNTH_OUTS = 15;
	localparam int CTL_PINS   = 8;
	localparam int SYNTHS     = 5;
	localparam int IFC_N      = 4;

	// ------------------------------------------------------------
	// source routing
	// ------------------------------------------------------------
	// pin mask for the left half; the right half is this shifted by 8
	localparam logic [15:0] PIN_BASE_MASK = 16'h0011;
	localparam int          RIGHT_SHIFT   = 8;

	// synth outputs in order: tl0, tl1, tr0, tr1, br0; outputs 0..2 each
	localparam logic [15:0] SYNTH_MASK [SYNTH_OUTS] = '{
		16'h0041, 16'h0006, 16'h0006,
		16'h0088, 16'h0030, 16'h0030,
		16'h4100, 16'h0600, 16'h0600,
		16'h8800, 16'h3000, 16'h3000,
		16'h8100, 16'h0600, 16'h0600
	};

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [15:0] LINE_RST    = 16'h0000;
	localparam logic [3:0]  IDX_RST     = 4'h0;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SRC_PIN,
		SRC_SYNTH,
		SRC_OSC,
		SRC_CORE
	} gcn_src_e;

	typedef struct packed {
		logic [3:0] line;
		gcn_src_e   kind;
		logic [3:0] idx;
	} gcn_cfg_s;

	typedef struct packed {
		gcn_src_e   kind;
		logic [3:0] idx;
		logic       valid;
	} gcn_sel_s;

	typedef struct packed {
		logic to_core;
		logic to_pad;
		logic clk_out;
	} gcn_ifc_s;

	typedef struct packed {
		logic [15:0] le;
		logic [15:0] mem;
		logic [15:0] mult;
		logic [15:0] io;
	} gcn_tree_s;

endpackage

/* verilog/gcn_root_gate.sv */
/*
 * Root enable gate for one global line.
 * Assumes src and en are already on core_clk; src is the sampled source.
 */
module gcn_root_gate (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic rst,
	// source and enable
	input  wire logic src,
	input  wire logic en,
	// gated line
	output logic      gated_r
);

	// ------------------------------------------------------------
	// enable hold
	// ------------------------------------------------------------
	logic en_hold_r;

	// enable may only change while the source is low, so a high phase
	// already begun is never cut short and none starts mid-phase
	always_ff @(posedge core_clk) begin
		if (rst) begin
			en_hold_r <= 1'b0;
		end else if (!src) begin
			en_hold_r <= en;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			gated_r <= 1'b0;
		end else begin
			gated_r <= src & en_hold_r;
		end
	end

endmodule

/* verification/gcn_checker.sv */
/*
 * concurrent checks on the clock network top ports.
 * assumes binding to gcn_global_clock_network, one clock, sync reset.
 */
module gcn_checker #(
	parameter int CTL_PINS = 8,
	parameter int IFC_N    = 4
) (
	// clock and reset
	input wire logic                          core_clk,
	input wire logic                          rst,
	// configuration
	input wire logic                          run,
	input wire logic                          cfg_valid,
	input wire logic                          cfg_accept_r,
	input wire logic                          cfg_reject_r,
	// trees and networks
	input wire gcn_pkg::gcn_tree_s            tree_r,
	input wire logic [CTL_PINS-1:0]           ctl_pin,
	input wire logic [CTL_PINS-1:0]           le_set_r,
	input wire logic [CTL_PINS-1:0]           le_reset_r,
	input wire logic [CTL_PINS-1:0]           le_ce_r,
	input wire logic [gcn_pkg::SYNTHS-1:0]    alt_pin,
	input wire logic [gcn_pkg::SYNTHS-1:0]    synth_ref_r,
	// interface blocks
	input wire gcn_pkg::gcn_ifc_s [IFC_N-1:0] ifc_in,
	input wire gcn_pkg::gcn_ifc_s [IFC_N-1:0] ifc_out_r
);
	timeunit 1ns;
	timeprecision 1ps;
	// --------------------------------
	// helpers
	// --------------------------------
	// cycles since reset; the two synchroniser stages plus the output register need three to refill
	logic [1:0]       rcnt_r;
	logic [IFC_N-1:0] clk_o;
	logic [IFC_N-1:0] pad_o;
	logic [IFC_N-1:0] pad_i;
	logic [IFC_N-1:0] core_o;
	logic [IFC_N-1:0] core_i;
	always_ff @(posedge core_clk) begin
		if (rst) rcnt_r <= 2'h0;
		else if (rcnt_r != 2'h3) rcnt_r <= rcnt_r + 2'h1;
	end
	always_comb begin
		for (int i = 0; i < IFC_N; i++) begin
			clk_o[i] = ifc_out_r[i].clk_out;
			pad_o[i] = ifc_out_r[i].to_pad;
			pad_i[i] = ifc_in[i].to_pad;
			core_o[i] = ifc_out_r[i].to_core;
			core_i[i] = ifc_in[i].to_core;
		end
	end
	// --------------------------------
	// properties
	// --------------------------------
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence answer_s;
		cfg_accept_r ^ cfg_reject_r;
	endsequence
	sequence settled_s;
		rcnt_r == 2'h3;
	endsequence
	answer_once_a: assert property (cfg_valid |=> answer_s)
		else $error("config request without single answer");
	answer_cause_a: assert property (answer_s |-> $past(cfg_valid))
		else $error("config answer without request");
	run_refuse_a: assert property (cfg_valid && run |=> cfg_reject_r)
		else $error("config accepted while running");
	tree_copies_a: assert property (tree_r.le == tree_r.mem &&
		tree_r.le == tree_r.mult && tree_r.le == tree_r.io)
		else $error("sink trees differ");
	ctl_net_a: assert property (settled_s |-> le_set_r == $past(ctl_pin, 3) &&
		le_reset_r == $past(ctl_pin, 3) && le_ce_r == $past(ctl_pin, 3))
		else $error("control network mismatch");
	alt_ref_a: assert property (settled_s |-> synth_ref_r == $past(alt_pin, 3))
		else $error("alternate reference mismatch");
	// clock output and tree are both loaded from the gate outputs on one edge
	ifc_clkout_a: assert property (rcnt_r != 2'h0 |->
		tree_r.le[IFC_N-1:0] == clk_o)
		else $error("interface clock not from tree");
	ifc_core_a: assert property (settled_s |-> core_o == $past(core_i, 3))
		else $error("interface input path mismatch");
	ifc_pad_a: assert property (rcnt_r != 2'h0 |-> pad_o == $past(pad_i))
		else $error("interface output path mismatch");
endmodule

/* verification/gcn_src_model.sv */
/*
 * far side model: pins, synth outputs, oscillator and fabric.
 * assumes one shared square wave of eight cycles for every source.
 */
module gcn_src_model (
	// clock
	input  wire logic                                  core_clk,
	// clock sources
	output logic [gcn_pkg::PINS_SIDE-1:0]              left_pin,
	output logic [gcn_pkg::PINS_SIDE-1:0]              right_pin,
	output logic [gcn_pkg::SYNTH_OUTS-1:0]             synth_output_clock,
	output logic                                       osc_clk,
	output logic [gcn_pkg::LINES-1:0]                  core_gen_clk,
	// control, alternate and interface data
	output logic [gcn_pkg::CTL_PINS-1:0]               ctl_pin,
	output logic [gcn_pkg::SYNTHS-1:0]                 alt_pin,
	output gcn_pkg::gcn_ifc_s [gcn_pkg::IFC_N-1:0]     ifc_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] cnt_r = 12'h000;
	logic        ph;
	// moves just after the edge, like any other driver
	always @(posedge core_clk) cnt_r <= #1 cnt_r + 12'h001;
	assign ph = cnt_r[2];
	assign left_pin = {gcn_pkg::PINS_SIDE{ph}};
	assign right_pin = {gcn_pkg::PINS_SIDE{ph}};
	assign synth_output_clock = {gcn_pkg::SYNTH_OUTS{ph}};
	assign osc_clk = ph;
	assign core_gen_clk = {gcn_pkg::LINES{ph}};
	assign ctl_pin = cnt_r[10:3];
	assign alt_pin = cnt_r[8:4];
	assign ifc_in = cnt_r;
endmodule

/* verification/global_clock_network_tb.sv */
/*
 * self-checking bench for the global clock network.
 * assumes the source model and checker files are compiled first.
 */
module global_clock_network_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic run = 1'b0;
	logic cfg_valid = 1'b0;
	logic [15:0] line_en = 16'h0000;
	gcn_pkg::gcn_cfg_s cfg = '0;
	logic [7:0] left_pin, right_pin, ctl_pin, le_set_r, le_reset_r, le_ce_r;
	logic [14:0] synth_output_clock;
	logic [15:0] core_gen_clk;
	logic [4:0] alt_pin, synth_ref_r;
	logic osc_clk, cfg_accept_r, cfg_reject_r;
	gcn_pkg::gcn_tree_s tree_r;
	gcn_pkg::gcn_ifc_s [3:0] ifc_in, ifc_out_r;
	int fails = 0;
	int n_tests = 0;
	always #10 core_clk = ~core_clk;
	gcn_src_model u_gcn_src_model (.core_clk, .left_pin, .right_pin,
		.synth_output_clock, .osc_clk, .core_gen_clk, .ctl_pin, .alt_pin, .ifc_in);
	gcn_global_clock_network u_gcn_global_clock_network (.core_clk, .rst,
		.left_pin, .right_pin, .synth_output_clock, .osc_clk, .core_gen_clk,
		.run, .cfg_valid, .cfg, .cfg_accept_r, .cfg_reject_r, .line_en, .tree_r,
		.ctl_pin, .le_set_r, .le_reset_r, .le_ce_r, .alt_pin, .synth_ref_r,
		.ifc_in, .ifc_out_r);
	// --------------------------------
	// tasks
	// --------------------------------
	task finish_test;
		$display("tests %0d fails %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task cfg_req(input logic [3:0] ln, input gcn_pkg::gcn_src_e k,
		input logic [3:0] ix, input logic ok);
		@(posedge core_clk);
		#1;
		cfg_valid = 1'b1;
		cfg = '{line: ln, kind: k, idx: ix};
		@(posedge core_clk);
		#1;
		cfg_valid = 1'b0;
		chk("cfg_accept_r", {15'h0000, ok}, {15'h0000, cfg_accept_r});
		chk("cfg_reject_r", {15'h0000, !ok}, {15'h0000, cfg_reject_r});
	endtask
	task t_reset;
		repeat (5) @(posedge core_clk);
		#1;
		chk("tree in reset", 16'h0000, tree_r.le);
		rst = 1'b0;
		@(posedge core_clk);
		#1;
		chk("tree after reset", 16'h0000, tree_r.le);
	endtask
	task t_routing;
		cfg_req(4'h0, gcn_pkg::SRC_PIN, 4'h4, 1'b1);
		cfg_req(4'h7, gcn_pkg::SRC_PIN, 4'h3, 1'b1);
		cfg_req(4'h5, gcn_pkg::SRC_PIN, 4'h0, 1'b0);
		cfg_req(4'h2, gcn_pkg::SRC_PIN, 4'h2, 1'b1);
		cfg_req(4'hc, gcn_pkg::SRC_PIN, 4'h4, 1'b1);
		cfg_req(4'hb, gcn_pkg::SRC_PIN, 4'h8, 1'b0);
		cfg_req(4'h6, gcn_pkg::SRC_SYNTH, 4'h0, 1'b1);
		cfg_req(4'h3, gcn_pkg::SRC_SYNTH, 4'h0, 1'b0);
		cfg_req(4'h4, gcn_pkg::SRC_SYNTH, 4'h5, 1'b1);
		cfg_req(4'he, gcn_pkg::SRC_SYNTH, 4'h6, 1'b1);
		cfg_req(4'hd, gcn_pkg::SRC_SYNTH, 4'ha, 1'b1);
		cfg_req(4'he, gcn_pkg::SRC_SYNTH, 4'hc, 1'b0);
		cfg_req(4'h9, gcn_pkg::SRC_SYNTH, 4'hf, 1'b0);
		cfg_req(4'hf, gcn_pkg::SRC_SYNTH, 4'hc, 1'b1);
		cfg_req(4'hf, gcn_pkg::SRC_OSC, 4'h0, 1'b1);
		cfg_req(4'ha, gcn_pkg::SRC_CORE, 4'h0, 1'b1);
	endtask
	task t_run;
		run = 1'b1;
		cfg_req(4'h2, gcn_pkg::SRC_PIN, 4'h2, 1'b0);
	endtask
	task t_gate;
		int hi;
		int rises;
		int runs;
		logic prev;
		hi = 0;
		rises = 0;
		runs = 0;
		line_en = 16'hffff;
		repeat (16) @(posedge core_clk);
		#1;
		// start in a low phase so the first counted high phase is whole
		while (tree_r.le[2] === 1'b1) begin
			@(posedge core_clk);
			#1;
		end
		prev = tree_r.le[15];
		// enable flips mid-phase; every high phase must stay whole
		for (int i = 0; i < 64; i++) begin
			@(posedge core_clk);
			#1;
			if (i % 5 == 0) line_en[2] = ~line_en[2];
			if (tree_r.le[15] === 1'b1 && prev === 1'b0) rises++;
			prev = tree_r.le[15];
			if (tree_r.le[2] === 1'b1) hi++;
			else if (hi != 0) begin
				chk("high phase", 16'h0004, 16'(hi));
				runs++;
				hi = 0;
			end
		end
		chk("line 15 rises", 16'h0008, 16'(rises));
		chk("gated phases seen", 16'h0001, {15'h0000, runs != 0});
		chk("refused line idle", 16'h0000, {15'h0000, tree_r.le[5]});
		line_en = 16'h0000;
		repeat (12) @(posedge core_clk);
		hi = 0;
		for (int i = 0; i < 16; i++) begin
			@(posedge core_clk);
			#1;
			if (tree_r.le !== 16'h0000) hi++;
		end
		chk("tree off", 16'h0000, 16'(hi));
	endtask
	// --------------------------------
	// sequence
	// --------------------------------
	initial begin
		#20000;
		fails++;
		finish_test();
	end
	initial begin
		t_reset();
		t_routing();
		t_run();
		t_gate();
		finish_test();
	end
endmodule
bind gcn_global_clock_network gcn_checker #(.CTL_PINS(CTL_PINS), .IFC_N(IFC_N))
	u_gcn_checker (.core_clk, .rst, .run, .cfg_valid, .cfg_accept_r,
	.cfg_reject_r, .tree_r, .ctl_pin, .le_set_r, .le_reset_r, .le_ce_r,
	.alt_pin, .synth_ref_r, .ifc_in, .ifc_out_r);
